// ---- verilog/external_data_memory_address_pointer_unit.sv ----
/*
  Address pointer unit: two data pointers with top bytes, pointer select and
  step control, addressing-mode control, relocation base and the forming of
  24-bit external data memory addresses for pointer and indirect moves.
  Assumes the execution core drives the special-function-register strobes and
  the instruction events on sys_clk, and a timed-access block outside raises
  timed_access_open for the cycle in which a guarded write is allowed.
  Every input comes from logic on sys_clk, so none of them is synchronised here.
*/
`include "external_data_memory_ptr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module external_data_memory_address_pointer_unit
  import external_data_memory_ptr_pkg::*;
#(
  parameter int unsigned DATA_MEM_BYTES = 32'd1792
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_rd,
  output logic [7:0]       sfr_rdata,
  output logic             sfr_hit,
  input  wire logic        timed_access_open,
  input  wire logic        ptr_step,
  input  wire logic        ptr_use,
  input  wire logic        ext_move_ptr,
  input  wire logic        ext_move_ind,
  input  wire logic [7:0]  work_reg,
  input  wire logic [7:0]  port_two_register,
  input  wire logic [7:0]  stack_low_byte,
  input  wire logic [7:0]  stack_high_byte,
  output logic [23:0]      external_data_memory_addr,
  output logic             external_data_memory_addr_valid,
  output logic [23:0]      external_data_memory_base_addr,
  output logic             flat_mode,
  output logic [4:0]       prog_addr_bits,
  output logic [15:0]      data_addr_mask,
  output logic [15:0]      vector_base,
  output logic [15:0]      stack_addr,
  output logic             stack_extended
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] p0_low_q, p0_low_d;
  logic [7:0] p0_high_q, p0_high_d;
  logic [7:0] p0_top_q, p0_top_d;
  logic [7:0] p1_low_q, p1_low_d;
  logic [7:0] p1_high_q, p1_high_d;
  logic [7:0] p1_top_q, p1_top_d;
  logic [7:0] ptr_sel_q, ptr_sel_d;
  logic [7:0] addr_mode_q, addr_mode_d;
  logic [7:0] reloc_q, reloc_d;
  logic [7:0] ind_page_q, ind_page_d;
  logic [7:0] ind_upper_q, ind_upper_d;
  logic [7:0] rdata_q, rdata_d;
  xaddr_t     xaddr_q, xaddr_d;
  logic       xvalid_q, xvalid_d;

  ////////////////////////////////////////////////////////////////////////////
  // Decoded controls
  addr_mode_e mode;
  logic       sel_one;
  logic       step_down;
  logic [23:0] cur_ptr;
  logic [23:0] stepped;
  logic       top_live;

  // Upper mode bit alone decides flat mode, lower bit is a don't-care
  assign mode = addr_mode_q[`MODE_HI_BIT] ? MODE_FLAT : MODE_WIDE16_PROGRAM_MODE; // R5
  assign sel_one = ptr_sel_q[`SEL_BIT]; // R14

  // Step field: low bit governs pointer 0, high bit pointer 1
  assign step_down = sel_one ? ptr_sel_q[`STEP_HI_BIT]
                             : ptr_sel_q[`STEP_LO_BIT]; // R12

  assign cur_ptr = sel_one ? {p1_top_q, p1_high_q, p1_low_q}
                           : {p0_top_q, p0_high_q, p0_low_q};

  // Top bytes only reach memory when it spans beyond 64KB
  assign top_live = (DATA_MEM_BYTES > `FULL_DATA_BYTES); // R16

  ////////////////////////////////////////////////////////////////////////////
  // Pointer step arithmetic
  // Both widths are formed every cycle; the mode only picks one of them
  always_comb begin
    logic [23:0] full;
    logic [15:0] low16;
    full = 24'h00_0000;
    low16 = 16'h0000;
    if (step_down) begin
      full  = cur_ptr - 24'h00_0001;
      low16 = cur_ptr[15:0] - 16'h0001;
    end else begin
      full  = cur_ptr + 24'h00_0001;
      low16 = cur_ptr[15:0] + 16'h0001;
    end
    if (mode == MODE_FLAT) begin
      stepped = full; // R15
    end else begin
      stepped = {cur_ptr[23:16], low16}; // R21
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register next state: writes, steps, toggling
  always_comb begin
    p0_low_d    = p0_low_q;
    p0_high_d   = p0_high_q;
    p0_top_d    = p0_top_q;
    p1_low_d    = p1_low_q;
    p1_high_d   = p1_high_q;
    p1_top_d    = p1_top_q;
    ptr_sel_d   = ptr_sel_q;
    addr_mode_d = addr_mode_q;
    reloc_d     = reloc_q;
    ind_page_d  = ind_page_q;
    ind_upper_d = ind_upper_q;

    // Step the selected pointer; a register write below overrides it
    if (ptr_step) begin
      if (sel_one) begin
        {p1_top_d, p1_high_d, p1_low_d} = stepped; // R12
      end else begin
        {p0_top_d, p0_high_d, p0_low_d} = stepped; // R12
      end
    end

    // Selection flips after the using instruction, which saw the old one
    if (ptr_use && ptr_sel_q[`TOGGLE_BIT]) begin
      ptr_sel_d[`SEL_BIT] = ~ptr_sel_q[`SEL_BIT]; // R13 R20
    end

    if (sfr_wr) begin
      case (sfr_addr)
        `OFS_P0_LOW: begin
          p0_low_d = sfr_wdata;
        end
        `OFS_P0_HIGH: begin
          p0_high_d = sfr_wdata;
        end
        `OFS_P0_TOP: begin
          p0_top_d = sfr_wdata;
        end
        `OFS_P1_LOW: begin
          p1_low_d = sfr_wdata;
        end
        `OFS_P1_HIGH: begin
          p1_high_d = sfr_wdata;
        end
        `OFS_P1_TOP: begin
          p1_top_d = sfr_wdata;
        end
        `OFS_PTR_SEL: begin
          ptr_sel_d = sfr_wdata & `PTR_SEL_WMASK;
        end
        // Guarded registers ignore writes outside the timed-access window
        `OFS_ADDR_MODE: begin
          // A refused write leaves no trace; software must open the window again
          if (timed_access_open) begin
            addr_mode_d = sfr_wdata & `ADDR_MODE_WMASK; // R18
          end
        end
        `OFS_EXTERNAL_DATA_MEMORY_RELOC: begin
          if (timed_access_open) begin
            reloc_d = sfr_wdata; // R18
          end
        end
        `OFS_IND_PAGE: begin
          ind_page_d = sfr_wdata;
        end
        `OFS_IND_UPPER: begin
          ind_upper_d = sfr_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; the stack indicator is hardware state, never stored
  // An unmapped offset reads as zero and drops sfr_hit
  always_comb begin
    sfr_hit = 1'b1;
    rdata_d = rdata_q;
    case (sfr_addr)
      `OFS_P0_LOW:     rdata_d = p0_low_q;
      `OFS_P0_HIGH:    rdata_d = p0_high_q;
      `OFS_P0_TOP:     rdata_d = p0_top_q;
      `OFS_P1_LOW:     rdata_d = p1_low_q;
      `OFS_P1_HIGH:    rdata_d = p1_high_q;
      `OFS_P1_TOP:     rdata_d = p1_top_q;
      `OFS_PTR_SEL:    rdata_d = ptr_sel_q; // R14
      `OFS_EXTERNAL_DATA_MEMORY_RELOC: rdata_d = reloc_q;
      `OFS_IND_PAGE:   rdata_d = ind_page_q;
      `OFS_IND_UPPER:  rdata_d = ind_upper_q;
      `OFS_ADDR_MODE: begin
        rdata_d = addr_mode_q;
        rdata_d[`STACK_IND_BIT] = stack_extended; // R8
      end
      default: begin
        sfr_hit = 1'b0;
        rdata_d = `RST_BYTE;
      end
    endcase
    if (!sfr_rd) begin
      rdata_d = rdata_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External move address forming, one cycle after the move request
  always_comb begin
    xaddr_d  = xaddr_q;
    xvalid_d = ext_move_ptr | ext_move_ind;
    // Both requests at once: the pointer move wins, the indirect one is dropped
    if (ext_move_ptr) begin
      // Pointer move: selected pointer, top byte included
      // Selection is the registered one, so a toggle in this cycle comes later
      xaddr_d = cur_ptr; // R10 R11
      if (!top_live) begin
        // Small memory: a stale top byte must not push the address out of range
        xaddr_d[23:16] = 8'h00; // R16
      end
    end else if (ext_move_ind) begin
      // Indirect move: upper byte, page source, then working register
      xaddr_d[23:16] = ind_upper_q; // R9
      xaddr_d[15:8]  = addr_mode_q[`PAGE_SRC_BIT] ? ind_page_q
                                                  : port_two_register; // R7
      xaddr_d[7:0]   = work_reg; // R17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  // Reset is synchronous, so a glitch between edges cannot clear them
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      p0_low_q    <= `RST_BYTE;
      p0_high_q   <= `RST_BYTE;
      p0_top_q    <= `RST_BYTE;
      p1_low_q    <= `RST_BYTE;
      p1_high_q   <= `RST_BYTE;
      p1_top_q    <= `RST_BYTE;
      ptr_sel_q   <= `RST_BYTE;
      addr_mode_q <= `RST_BYTE; // R18
      reloc_q     <= `RST_BYTE; // R18
      ind_page_q  <= `RST_BYTE;
      ind_upper_q <= `RST_BYTE;
      rdata_q     <= `RST_BYTE;
      xaddr_q     <= 24'h00_0000;
      xvalid_q    <= 1'b0;
    end else begin
      p0_low_q    <= p0_low_d;
      p0_high_q   <= p0_high_d;
      p0_top_q    <= p0_top_d;
      p1_low_q    <= p1_low_d;
      p1_high_q   <= p1_high_d;
      p1_top_q    <= p1_top_d;
      ptr_sel_q   <= ptr_sel_d;
      addr_mode_q <= addr_mode_d;
      reloc_q     <= reloc_d;
      ind_page_q  <= ind_page_d;
      ind_upper_q <= ind_upper_d;
      rdata_q     <= rdata_d;
      xaddr_q     <= xaddr_d;
      xvalid_q    <= xvalid_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode outputs to the core and memory
  assign sfr_rdata       = rdata_q;
  assign external_data_memory_addr       = xaddr_q; // R11
  assign external_data_memory_addr_valid = xvalid_q;
  assign flat_mode       = (mode == MODE_FLAT);

  // Relocation base in 2KB steps; left at zero by software on this part
  assign external_data_memory_base_addr = {5'b00000, reloc_q, 11'h000}; // R1 R2

  // Program address width per mode
  assign prog_addr_bits = (mode == MODE_FLAT) ? 5'd20 : 5'd16; // R3

  // Data space never widens with the mode
  assign data_addr_mask = 16'hFFFF; // R4

  assign vector_base = addr_mode_q[`VEC_SEL_BIT] ? `VEC_RELOC_BASE
                                                  : `VEC_NORMAL_BASE; // R6

  // Stack lives in data space only in flat mode
  // Otherwise it stays in the 256-byte internal memory, high byte zero
  assign stack_extended = (mode == MODE_FLAT); // R8 R3
  assign stack_addr = stack_extended ? {stack_high_byte, stack_low_byte}
                                     : {8'h00, stack_low_byte}; // R19

endmodule
`default_nettype wire

// ---- verilog/external_data_memory_ptr_cfg.svh ----
/*
  Constants of the address pointer unit: special-function-register offsets,
  field positions, reset values and address-forming figures.
  Assumes it is included by its bare name, after or before the type package.
*/
`ifndef EXTERNAL_DATA_MEMORY_PTR_CFG_SVH
`define EXTERNAL_DATA_MEMORY_PTR_CFG_SVH

// Overview of operation
// R1 - Relocation register gives external memory start address in 2KB steps.
// R2 - Software should leave the relocation register at zero on this part.
// R3 - Wide16_program_mode mode: 16-bit program addresses; flat mode: 20-bit, stack in data space.
// R4 - Data-space address width stays 16 bits in both modes.
// R5 - Mode field 00 selects wide16_program_mode mode; upper bit one selects flat mode.
// R6 - Vector select one puts vectors at B000, zero at 0x0000.
// R7 - Indirect move high byte from port two register, or page register when enabled.
// R8 - Read-only stack indicator: zero internal stack, one extended 16-bit stack.
// R9 - Indirect upper byte supplies bits 23..16 only for indirect moves.
// R10 - Pointer moves take bits 23..16 from selected pointer's top byte.
// R11 - External data memory address path is 24 bits wide.
// R12 - Step field sets increment or decrement per pointer.
// R13 - Toggle bit flips pointer selection each time a pointer is used.
// R14 - Select bit picks pointer 1 when set; reads show current selection.
// R15 - Flat mode steps the full 24-bit pointer; wide16_program_mode mode keeps top byte.
// R16 - Top byte has no effect when data memory is under 64KB.
// R17 - Indirect move low byte comes from the working register.
// R18 - Mode and relocation writes need timed access; both reset to zero.
// R19 - Flat mode stack address is stack high byte over stack low byte.
// R20 - Selection change takes effect after the pointer-using instruction completes.
// R21 - Wide16_program_mode mode steps wrap within 16 bits, top byte untouched.

// Register offsets
`define OFS_P0_LOW        8'h82
`define OFS_P0_HIGH       8'h83
`define OFS_P1_LOW        8'h84
`define OFS_P1_HIGH       8'h85
`define OFS_PTR_SEL       8'h86
`define OFS_P0_TOP        8'h93
`define OFS_P1_TOP        8'h95
`define OFS_ADDR_MODE     8'h9D
`define OFS_EXTERNAL_DATA_MEMORY_RELOC    8'hC6
`define OFS_IND_PAGE      8'hDA
`define OFS_IND_UPPER     8'hEA

// Field positions
`define SEL_BIT           0
`define TOGGLE_BIT        5
`define STEP_LO_BIT       6
`define STEP_HI_BIT       7
`define MODE_LO_BIT       0
`define MODE_HI_BIT       1
`define STACK_IND_BIT     2
`define PAGE_SRC_BIT      3
`define VEC_SEL_BIT       5
`define PTR_SEL_WMASK     8'hE1
`define ADDR_MODE_WMASK   8'h2B

// Reset values
`define RST_BYTE          8'h00

// Address forming
`define RELOC_STEP_SHIFT  11
`define VEC_RELOC_BASE    16'hB000
`define VEC_NORMAL_BASE   16'h0000
`define FULL_DATA_BYTES   32'h0001_0000

`endif

// ---- verilog/external_data_memory_ptr_pkg.sv ----
/*
  Types shared by the address pointer unit.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package external_data_memory_ptr_pkg;
  typedef enum logic {MODE_WIDE16_PROGRAM_MODE, MODE_FLAT} addr_mode_e;
  typedef logic [23:0] xaddr_t;
endpackage
`default_nettype wire

// ---- dv/external_data_memory_ptr_checker_assertions.sv ----
/*
  Port-level assertions for the address pointer unit.
  Assumes sys_clk and an active-high synchronous reset, bound to the top.
*/
`timescale 1ns/1ps
`default_nettype none

module external_data_memory_ptr_checker (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        ext_move_ptr,
  input wire logic        ext_move_ind,
  input wire logic [7:0]  work_reg,
  input wire logic [7:0]  stack_low_byte,
  input wire logic [7:0]  stack_high_byte,
  input wire logic [23:0] external_data_memory_addr,
  input wire logic        external_data_memory_addr_valid,
  input wire logic        flat_mode,
  input wire logic [4:0]  prog_addr_bits,
  input wire logic [15:0] data_addr_mask,
  input wire logic [15:0] stack_addr,
  input wire logic        stack_extended
);
  ////////////////////////////////////////////////////////////////
  // One domain, so clock and reset are declared once
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_valid_follows: assert property ((ext_move_ptr || ext_move_ind) |=> external_data_memory_addr_valid)
    else $error("move request gave no valid");
  a_valid_cause: assert property (external_data_memory_addr_valid |-> $past(ext_move_ptr || ext_move_ind))
    else $error("valid without a request");
  a_ind_low_byte: assert property ((ext_move_ind && !ext_move_ptr) |=>
    external_data_memory_addr[7:0] == $past(work_reg)) else $error("indirect low byte wrong");
  a_addr_holds: assert property (!(ext_move_ptr || ext_move_ind) |=> $stable(external_data_memory_addr))
    else $error("address moved without request");
  a_prog_width: assert property (prog_addr_bits == (flat_mode ? 5'd20 : 5'd16))
    else $error("program width wrong");
  a_data_width: assert property (data_addr_mask == 16'hFFFF)
    else $error("data width not 16");
  a_stack_flat: assert property (flat_mode |-> stack_addr == {stack_high_byte,
    stack_low_byte}) else $error("flat stack address wrong");
  a_stack_mode: assert property (stack_extended == flat_mode)
    else $error("stack indicator wrong");
  a_stack_wide16_program_mode: assert property (!flat_mode |-> stack_addr == {8'h00, stack_low_byte})
    else $error("wide16_program_mode stack address wrong");
endmodule

bind external_data_memory_address_pointer_unit external_data_memory_ptr_checker u_chk (.sys_clk, .reset, .ext_move_ptr,
  .ext_move_ind, .work_reg, .stack_low_byte, .stack_high_byte, .external_data_memory_addr, .external_data_memory_addr_valid,
  .flat_mode, .prog_addr_bits, .data_addr_mask, .stack_addr, .stack_extended);

`default_nettype wire

// ---- dv/external_data_memory_mem_model.sv ----
/*
  Data memory seen from the unit: counts each address strobe it accepts.
  Assumes one strobe per move, sampled on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module external_data_memory_mem_model (
  input wire logic        sys_clk,
  input wire logic [23:0] addr,
  input wire logic        valid,
  output int              hits
);
  // A strobe held two cycles counts twice, which the bench catches
  // The two-state count starts at zero, so one process drives it
  always @(posedge sys_clk) begin
    if (valid && addr !== 24'hXXXXXX) hits++;
  end
endmodule

`default_nettype wire

// ---- dv/external_data_memory_address_pointer_unit_tb_top.sv ----
/*
  Self-checking bench for the address pointer unit with a memory model.
  Assumes the design package and a 40 MHz sys_clk; inputs move on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none

module external_data_memory_address_pointer_unit_tb_top;
  import external_data_memory_ptr_pkg::*;
  logic        sys_clk, reset, sfr_wr, sfr_rd, timed_access_open, sfr_hit, rd_p, g;
  logic        ptr_step, ptr_use, ext_move_ptr, ext_move_ind, flat_mode, stack_extended;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, work_reg, port_two_register, d, a, b;
  logic [7:0]  stack_low_byte, stack_high_byte;
  logic [4:0]  prog_addr_bits;
  logic [15:0] data_addr_mask, vector_base, stack_addr;
  logic [31:0] rs;
  xaddr_t      external_data_memory_addr, external_data_memory_base_addr, p0, p1;
  logic        external_data_memory_addr_valid;
  logic [7:0]  exp_rd[$];
  xaddr_t      exp_mv[$];
  int          bad_count, n_tests, hits, nmv;
  logic [7:0]  ofs[11] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h93, 8'h95, 8'h9D, 8'hC6,
                          8'hDA, 8'hEA};
  logic [7:0]  po[6] = '{8'h82, 8'h83, 8'h93, 8'h84, 8'h85, 8'h95};

  external_data_memory_address_pointer_unit #(.DATA_MEM_BYTES(131072)) u_dut (.sys_clk, .reset, .sfr_addr,
    .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata, .sfr_hit, .timed_access_open, .ptr_step,
    .ptr_use, .ext_move_ptr, .ext_move_ind, .work_reg, .port_two_register, .stack_low_byte,
    .stack_high_byte,
    .external_data_memory_addr, .external_data_memory_addr_valid, .external_data_memory_base_addr, .flat_mode, .prog_addr_bits,
    .data_addr_mask, .vector_base, .stack_addr, .stack_extended);
  external_data_memory_mem_model u_mem (.sys_clk, .addr(external_data_memory_addr), .valid(external_data_memory_addr_valid), .hits);

  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction
  // Readback as the masks and the read-only stack bit shape it
  function automatic logic [7:0] msk(logic [7:0] ad, logic [7:0] v);
    if (ad == 8'h86) return v & 8'hE1;
    if (ad == 8'h9D) return (v & 8'h2B) | {5'h0, v[1], 2'h0};
    return v;
  endfunction
  function automatic xaddr_t stepv(xaddr_t v, logic dn, logic fl);
    xaddr_t n = dn ? v - 24'h1 : v + 24'h1;
    return fl ? n : {v[23:16], n[15:0]};
  endfunction
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // op 0 idle, 1 write, 2 read with d as expected data; strobes held, never pulsed twice
  task automatic bus(int op, logic [7:0] ad = 0, logic [7:0] dd = 0, logic t = 1);
    sfr_wr = op == 1;
    sfr_rd = op == 2;
    sfr_addr = ad;
    sfr_wdata = dd;
    timed_access_open = t;
    if (op == 2) exp_rd.push_back(msk(ad, dd));
    @(negedge sys_clk);
  endtask
  task automatic ev(logic s, logic u, logic p, logic i, xaddr_t e = 0);
    {ptr_step, ptr_use, ext_move_ptr, ext_move_ind} = {s, u, p, i};
    if (p | i) exp_mv.push_back(e);
    nmv += int'(p | i);
    @(negedge sys_clk);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // Clock, watchdog and result monitor
  initial begin
    sys_clk = 0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    #100us;
    bad_count++;
    results();
  end
  always @(posedge sys_clk) rd_p <= sfr_rd;
  always @(negedge sys_clk) begin
    if (rd_p) chk("rdata", sfr_rdata, exp_rd.pop_front());
    if (external_data_memory_addr_valid) chk("xaddr", external_data_memory_addr, exp_mv.pop_front());
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    {sfr_wr, sfr_rd, timed_access_open, ptr_step, ptr_use, ext_move_ptr, ext_move_ind} = 0;
    {sfr_addr, sfr_wdata, work_reg, port_two_register, stack_low_byte} = 0;
    stack_high_byte = 0;
    {bad_count, n_tests, nmv} = 0;
    rs = 32'hCD34;
    reset = 1;
    repeat (8) @(negedge sys_clk);
    reset = 0;
    @(negedge sys_clk);
    foreach (ofs[k]) begin
      bus(2, ofs[k], 8'h00);
      chk("hit", sfr_hit, 1);
    end
    // Guarded places keep the first value when the second lacks the window
    foreach (ofs[k]) begin
      d = rnd();
      g = ofs[k] == 8'h9D || ofs[k] == 8'hC6;
      bus(1, ofs[k], d);
      bus(1, ofs[k], ~d, 0);
      bus(2, ofs[k], g ? d : ~d);
    end
    bus(2, 8'h81);
    chk("hit", sfr_hit, 0);
    bus(1, 8'hC6, 8'h81);
    chk("base", external_data_memory_base_addr, {5'h0, 8'h81, 11'h0});
    bus(1, 8'hC6, 8'h00);
    $display("register test done");
    for (int m = 0; m < 8; m++) begin
      stack_low_byte = rnd();
      stack_high_byte = rnd();
      bus(1, 8'h9D, {2'h0, m[2], 3'h0, m[1:0]});
      chk("flat", flat_mode, m[1]);
      chk("pbits", prog_addr_bits, m[1] ? 20 : 16);
      chk("vector", vector_base, m[2] ? 16'hB000 : 16'h0000);
      chk("stack", stack_addr, {m[1] ? stack_high_byte : 8'h00, stack_low_byte});
      chk("stackind", stack_extended, m[1]);
      chk("dmask", data_addr_mask, 16'hFFFF);
      bus(2, 8'h9D, {2'h0, m[2], 3'h0, m[1:0]});
    end
    $display("mode test done");
    for (int e = 0; e < 2; e++) begin
      a = rnd();
      b = rnd();
      bus(1, 8'h9D, {4'h0, e[0], 3'h0});
      bus(1, 8'hDA, a);
      bus(1, 8'hEA, b);
      bus(0);
      work_reg = rnd();
      port_two_register = rnd();
      ev(0, 0, 0, 1, {b, e[0] ? a : port_two_register, work_reg});
      ev(0, 0, 0, 1, {b, e[0] ? a : port_two_register, work_reg});
      ev(0, 0, 0, 0);
    end
    $display("indirect test done");
    // Step codes in both modes, starting at carry and borrow boundaries
    for (int c = 0; c < 8; c++) begin
      p0 = c[0] ? 24'h010000 : 24'h00FFFF;
      p1 = c[1] ? 24'h7F0000 : 24'h7FFFFF;
      bus(1, 8'h9D, {6'h0, c[2], 1'b0});
      bus(1, 8'h86, {c[1:0], 6'h20});
      for (int j = 0; j < 6; j++) bus(1, po[j], j < 3 ? p0[8*j +: 8] : p1[8*j-24 +: 8]);
      bus(0);
      ev(1, 0, 0, 0);
      p0 = stepv(p0, c[0], c[2]);
      ev(0, 1, 1, 0, p0);
      ev(1, 0, 0, 0);
      p1 = stepv(p1, c[1], c[2]);
      ev(0, 0, 1, 0, p1);
      ev(0, 0, 0, 0);
      bus(2, 8'h86, {c[1:0], 6'h21});
      bus(0);
    end
    $display("pointer test done");
    @(negedge sys_clk);
    chk("moves", hits, nmv);
    chk("reads left", exp_rd.size(), 0);
    chk("moves left", exp_mv.size(), 0);
    results();
  end
endmodule

`default_nettype wire
